// ### rtl/rmf_pkg.sv
// constants, types and helpers shared by the telegram framer
package rmf_pkg;

  // ****************************
  // timing
  // ****************************
  localparam int CLK_MHZ = 40;
  localparam int REPLY_DELAY_US = 100000;
  localparam int RTU_GAP_US = 4000;
  localparam int REPLY_DELAY_CYC = REPLY_DELAY_US * CLK_MHZ;
  localparam int RTU_GAP_CYC = RTU_GAP_US * CLK_MHZ;
  localparam int TMR_W = 23;

  // ****************************
  // drive protocol layout
  // ****************************
  localparam logic [7:0] DRV_START = 8'h02;
  localparam logic [7:0] DRV_LEN = 8'h0c;
  localparam int DRV_BCAST_BIT = 5;
  localparam logic [7:0] DRV_ADDR_KEEP = 8'h3f;
  localparam int DRV_WORDS = 5;
  localparam logic [7:0] DRV_LAST_IDX = 8'h0c;
  localparam logic [7:0] DRV_WORD_BASE = 8'h03;

  // ****************************
  // modbus layout
  // ****************************
  localparam logic [7:0] FC_RD_BITS_OUT = 8'h01;
  localparam logic [7:0] FC_RD_BITS_IN = 8'h02;
  localparam logic [7:0] FC_RD_WORDS_OUT = 8'h03;
  localparam logic [7:0] FC_RD_WORDS_IN = 8'h04;
  localparam logic [7:0] FC_WR_BIT = 8'h05;
  localparam logic [7:0] FC_WR_WORD = 8'h06;
  localparam logic [7:0] FC_WR_BITS = 8'h0f;
  localparam logic [7:0] FC_WR_WORDS = 8'h10;
  localparam logic [7:0] FC_ERR_FLAG = 8'h80;
  localparam logic [15:0] BIT_OFF = 16'h0000;
  localparam logic [15:0] BIT_ON = 16'hff00;
  localparam logic [7:0] MB_BCAST_ADDR = 8'h00;
  localparam logic [7:0] MB_MAX_BYTES = 8'hfa;
  localparam logic [7:0] MB_MIN_BYTES = 8'h03;
  localparam logic [7:0] MB_WORD_BASE = 8'h02;
  localparam logic [7:0] MB_LAST_IDX = 8'h05;
  localparam logic [7:0] MB_MULTI_LAST_IDX = 8'h06;
  localparam logic [7:0] ASCII_START = 8'h3a;
  localparam logic [7:0] ASCII_CR = 8'h0d;
  localparam logic [7:0] ASCII_LF = 8'h0a;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;

  typedef enum {S_IDLE, S_GAP, S_HDR, S_BODY, S_PAY, S_CHK, S_TAIL, S_DRAIN, S_WAIT} rmf_state_e;
  typedef enum logic [2:0] {ST_OK, ST_SLAVE_ERR, ST_CHECK_ERR, ST_BAD_REPLY, ST_TIMEOUT,
                            ST_REFUSED, ST_BCAST} rmf_status_e;

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    return (n < 4'ha) ? 8'(8'h30 + {4'h0, n}) : 8'(8'h37 + {4'h0, n});
  endfunction

  function automatic logic is_hex(input logic [7:0] c);
    return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66);
  endfunction

  function automatic logic [3:0] hex_val(input logic [7:0] c);
    logic [7:0] v;
    v = (c <= 8'h39) ? 8'(c - 8'h30) : (c <= 8'h46) ? 8'(c - 8'h37) : 8'(c - 8'h57);
    return v[3:0];
  endfunction

endpackage

// ### rtl/rmf_check.sv
// running check values: modbus crc, ascii sum and block xor
module rmf_check (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic en,
  input wire logic [7:0] din,
  output logic [15:0] crc_q,
  output logic [7:0] sum_q,
  output logic [7:0] bcc_q
);
  import rmf_pkg::*;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  always_ff @(posedge sys_clk) begin
    if (rst || clr) begin
      crc_q <= CRC_INIT;
      sum_q <= 8'h00;
      bcc_q <= 8'h00;
    end else if (en) begin
      crc_q <= crc_step(crc_q, din);
      sum_q <= 8'(sum_q + din);
      bcc_q <= bcc_q ^ din;
    end
  end
endmodule

// ### rtl/rmf_timer.sv
// one-shot down counter with a single-cycle expiry pulse
module rmf_timer #(
  parameter int W = 23
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [W-1:0] val,
  output logic expire_q,
  output logic busy_q
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      expire_q <= 1'b0;
    end else begin
      expire_q <= 1'b0;
      if (load) begin
        cnt_q <= val;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (cnt_q <= W'(1)) begin
          busy_q <= 1'b0;
          expire_q <= 1'b1;
        end else begin
          cnt_q <= W'(cnt_q - W'(1));
        end
      end
    end
  end
endmodule

// ### rtl/rmf_framer.sv
// master telegram framer for drive protocol and modbus rtu/ascii
module rmf_framer #(
  parameter int REPLY_CYC = rmf_pkg::REPLY_DELAY_CYC,
  parameter int GAP_CYC = rmf_pkg::RTU_GAP_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cfg_valid,
  input wire logic cfg_ascii,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_drive,
  input wire logic req_write,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_func,
  input wire logic [15:0] req_w0,
  input wire logic [15:0] req_w1,
  input wire logic [15:0] req_w2,
  input wire logic [15:0] req_w3,
  input wire logic [15:0] req_w4,
  input wire logic [7:0] req_pay_len,
  input wire logic pay_valid,
  output logic pay_ready,
  input wire logic [7:0] pay_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_char,
  input wire logic rx_valid,
  input wire logic [7:0] rx_char,
  output logic rsp_valid,
  output logic [7:0] rsp_byte,
  output logic done,
  output rmf_pkg::rmf_status_e status
);
  import rmf_pkg::*;

  // ****************************
  // state
  // ****************************
  rmf_state_e state_q;
  rmf_status_e status_q, eval_st;
  logic ascii_q, mb_q, bcast_q, multi_q, nib_q, have_q;
  logic [7:0] addr_q, func_q, plen_q, pleft_q, pbyte_q, idx_q;
  logic [15:0] word_q [DRV_WORDS];
  logic [7:0] tx_char_q, rsp_byte_q;
  logic tx_valid_q, req_ready_q, pay_ready_q, rsp_valid_q, done_q;
  logic rin_q, rnib_q, fin_q;
  logic [3:0] rhi_q;
  logic [7:0] rcnt_q, r1_q, h0_q, h1_q;
  logic [1:0] hcnt_q, depth;
  logic req_take, req_wr, req_fc_ok, req_bcast, req_multi, refuse;
  logic [7:0] cur_byte, wk, body_last, chk_last, rb;
  logic cur_raw, emit_en, use_hex, slot_free, adv, rb_v, fin, drv_end, chk_ok, enough;
  logic gap_ld, gap_exp, rpl_ld, rpl_exp, chk_clr, chk_en;
  logic [7:0] chk_din, sum, bcc;
  logic [15:0] crc;

  // ****************************
  // request decode
  // ****************************
  assign req_take = req_valid && req_ready_q;

  always_comb begin
    req_wr = req_drive ? req_write
           : (req_func inside {FC_WR_BIT, FC_WR_WORD, FC_WR_BITS, FC_WR_WORDS});
    req_fc_ok = req_drive || req_wr
           || (req_func inside {FC_RD_BITS_OUT, FC_RD_BITS_IN,
                                FC_RD_WORDS_OUT, FC_RD_WORDS_IN});
    req_bcast = req_drive ? req_addr[DRV_BCAST_BIT] : (req_addr == MB_BCAST_ADDR);
    req_multi = !req_drive && (req_func == FC_WR_BITS || req_func == FC_WR_WORDS);
    refuse = !req_fc_ok || (req_bcast && !req_wr)
           || (req_multi && (req_pay_len == 8'h00 || req_pay_len > MB_MAX_BYTES));
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ascii_q <= 1'b0;
    end else if (cfg_valid && state_q == S_IDLE) begin
      ascii_q <= cfg_ascii;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mb_q <= 1'b0;
      bcast_q <= 1'b0;
      multi_q <= 1'b0;
      addr_q <= 8'h00;
      func_q <= 8'h00;
      plen_q <= 8'h00;
      for (int i = 0; i < DRV_WORDS; i++) begin
        word_q[i] <= 16'h0000;
      end
    end else if (req_take && !refuse) begin
      mb_q <= !req_drive;
      bcast_q <= req_bcast;
      multi_q <= req_multi;
      addr_q <= req_drive ? (req_addr & DRV_ADDR_KEEP) : req_addr;
      func_q <= req_func;
      plen_q <= req_pay_len;
      word_q[0] <= req_w0;
      word_q[1] <= (!req_drive && req_func == FC_WR_BIT)
                 ? ((req_w1 != 16'h0000) ? BIT_ON : BIT_OFF) : req_w1;
      word_q[2] <= req_w2;
      word_q[3] <= req_w3;
      word_q[4] <= req_w4;
    end
  end

  // ****************************
  // outgoing byte selection
  // ****************************
  always_comb begin
    cur_byte = 8'h00;
    cur_raw = 1'b0;
    wk = 8'(idx_q - (mb_q ? MB_WORD_BASE : DRV_WORD_BASE));
    body_last = !mb_q ? DRV_LAST_IDX : (multi_q ? MB_MULTI_LAST_IDX : MB_LAST_IDX);
    chk_last = (mb_q && !ascii_q) ? 8'h01 : 8'h00;
    unique case (state_q)
      S_HDR: begin
        cur_byte = ASCII_START;
        cur_raw = 1'b1;
      end
      S_TAIL: begin
        cur_byte = (idx_q == 8'h00) ? ASCII_CR : ASCII_LF;
        cur_raw = 1'b1;
      end
      S_PAY: cur_byte = pbyte_q;
      S_CHK: begin
        if (!mb_q) begin
          cur_byte = bcc;
        end else if (ascii_q) begin
          cur_byte = 8'(~sum + 8'h01);
        end else begin
          cur_byte = (idx_q == 8'h00) ? crc[7:0] : crc[15:8];
        end
      end
      S_BODY: begin
        if (!mb_q && idx_q == 8'h00) begin
          cur_byte = DRV_START;
        end else if (!mb_q && idx_q == 8'h01) begin
          cur_byte = DRV_LEN;
        end else if (!mb_q && idx_q == 8'h02) begin
          cur_byte = addr_q;
        end else if (mb_q && idx_q == 8'h00) begin
          cur_byte = addr_q;
        end else if (mb_q && idx_q == 8'h01) begin
          cur_byte = func_q;
        end else if (mb_q && idx_q == MB_MULTI_LAST_IDX) begin
          cur_byte = plen_q;
        end else begin
          cur_byte = wk[0] ? word_q[wk[3:1]][7:0] : word_q[wk[3:1]][15:8];
        end
      end
      default: cur_byte = 8'h00;
    endcase
  end

  // ****************************
  // character emitter
  // ****************************
  assign emit_en = (state_q inside {S_HDR, S_BODY, S_CHK, S_TAIL}) || (state_q == S_PAY && have_q);
  assign use_hex = ascii_q && mb_q && !cur_raw;
  assign slot_free = !tx_valid_q || tx_ready;
  assign adv = emit_en && slot_free && (!use_hex || nib_q);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_valid_q <= 1'b0;
      tx_char_q <= 8'h00;
      nib_q <= 1'b0;
    end else if (emit_en && slot_free) begin
      tx_valid_q <= 1'b1;
      tx_char_q <= !use_hex ? cur_byte
                 : hex_char(nib_q ? cur_byte[3:0] : cur_byte[7:4]);
      nib_q <= use_hex && !nib_q;
    end else if (tx_ready) begin
      tx_valid_q <= 1'b0;
    end
  end

  // ****************************
  // payload intake
  // ****************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pay_ready_q <= 1'b0;
      have_q <= 1'b0;
      pbyte_q <= 8'h00;
      pleft_q <= 8'h00;
    end else if (req_take && !refuse) begin
      pleft_q <= req_multi ? req_pay_len : 8'h00;
      have_q <= 1'b0;
    end else if (pay_ready_q && pay_valid) begin
      pbyte_q <= pay_data;
      have_q <= 1'b1;
      pleft_q <= 8'(pleft_q - 8'h01);
      pay_ready_q <= 1'b0;
    end else begin
      pay_ready_q <= state_q == S_PAY && !have_q && pleft_q != 8'h00;
      if (state_q == S_PAY && adv) begin
        have_q <= 1'b0;
      end
    end
  end

  // ****************************
  // sequencer
  // ****************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= S_IDLE;
      idx_q <= 8'h00;
    end else begin
      unique case (state_q)
        S_IDLE: if (req_take && !refuse) begin
          idx_q <= 8'h00;
          state_q <= req_drive ? S_BODY : (ascii_q ? S_HDR : S_GAP);
        end
        S_GAP: if (gap_exp) state_q <= S_BODY;
        S_HDR: if (adv) state_q <= S_BODY;
        S_BODY: if (adv) begin
          if (idx_q == body_last) begin
            idx_q <= 8'h00;
            state_q <= multi_q ? S_PAY : S_CHK;
          end else begin
            idx_q <= 8'(idx_q + 8'h01);
          end
        end
        S_PAY: if (!have_q && pleft_q == 8'h00) state_q <= S_CHK;
        S_CHK: if (adv) begin
          if (idx_q == chk_last) begin
            idx_q <= 8'h00;
            state_q <= (mb_q && ascii_q) ? S_TAIL : S_DRAIN;
          end else begin
            idx_q <= 8'(idx_q + 8'h01);
          end
        end
        S_TAIL: if (adv) begin
          if (idx_q == 8'h01) begin
            idx_q <= 8'h00;
            state_q <= S_DRAIN;
          end else begin
            idx_q <= 8'(idx_q + 8'h01);
          end
        end
        S_DRAIN: if (!tx_valid_q) state_q <= bcast_q ? S_IDLE : S_WAIT;
        S_WAIT: if (fin || rpl_exp) state_q <= S_IDLE;
      endcase
    end
  end

  // ****************************
  // timers and check unit
  // ****************************
  assign gap_ld = (req_take && !refuse && !req_drive && !ascii_q)
               || (state_q == S_WAIT && rx_valid && mb_q && !ascii_q);
  assign rpl_ld = state_q == S_DRAIN && !tx_valid_q && !bcast_q;
  assign chk_clr = req_take || rpl_ld;
  assign chk_en = (adv && (state_q == S_BODY || state_q == S_PAY)) || rb_v;
  assign chk_din = (state_q == S_WAIT) ? rb : cur_byte;

  rmf_timer #(.W(TMR_W)) u_gap (
    .sys_clk(sys_clk), .rst(rst), .load(gap_ld), .val(TMR_W'(GAP_CYC)),
    .expire_q(gap_exp), .busy_q()
  );

  rmf_timer #(.W(TMR_W)) u_reply (
    .sys_clk(sys_clk), .rst(rst), .load(rpl_ld), .val(TMR_W'(REPLY_CYC)),
    .expire_q(rpl_exp), .busy_q()
  );

  rmf_check u_chk (
    .sys_clk(sys_clk), .rst(rst), .clr(chk_clr), .en(chk_en), .din(chk_din),
    .crc_q(crc), .sum_q(sum), .bcc_q(bcc)
  );

  // ****************************
  // reply parsing
  // ****************************
  always_comb begin
    rb = rx_char;
    if (!mb_q) begin
      rb_v = state_q == S_WAIT && rx_valid && !fin_q
          && (rcnt_q != 8'h00 || rx_char == DRV_START);
      fin = fin_q;
    end else if (ascii_q) begin
      rb = {rhi_q, hex_val(rx_char)};
      rb_v = state_q == S_WAIT && rx_valid && rin_q && is_hex(rx_char) && rnib_q;
      fin = state_q == S_WAIT && rx_valid && rin_q && rx_char == ASCII_LF;
    end else begin
      rb_v = state_q == S_WAIT && rx_valid;
      fin = state_q == S_WAIT && gap_exp && rcnt_q != 8'h00;
    end
    drv_end = rb_v && !mb_q && rcnt_q >= 8'h02 && {1'b0, rcnt_q} == {1'b0, r1_q} + 9'h001;
  end

  always_ff @(posedge sys_clk) begin
    if (rst || state_q != S_WAIT) begin
      rin_q <= 1'b0;
      rnib_q <= 1'b0;
      rhi_q <= 4'h0;
      rcnt_q <= 8'h00;
      r1_q <= 8'h00;
      fin_q <= 1'b0;
    end else begin
      fin_q <= fin_q || drv_end;
      if (mb_q && ascii_q && rx_valid) begin
        if (rx_char == ASCII_START) begin
          rin_q <= 1'b1;
          rnib_q <= 1'b0;
        end else if (rin_q && is_hex(rx_char)) begin
          rnib_q <= !rnib_q;
          rhi_q <= hex_val(rx_char);
        end
      end
      if (rb_v) begin
        rcnt_q <= (rcnt_q == 8'hff) ? rcnt_q : 8'(rcnt_q + 8'h01);
        if (rcnt_q == 8'h01) begin
          r1_q <= rb;
        end
      end
    end
  end

  // reply bytes held back so the check field never reaches the user
  assign depth = (mb_q && !ascii_q) ? 2'd2 : 2'd1;

  always_ff @(posedge sys_clk) begin
    if (rst || state_q != S_WAIT) begin
      hcnt_q <= 2'd0;
      h0_q <= 8'h00;
      h1_q <= 8'h00;
      rsp_valid_q <= 1'b0;
      rsp_byte_q <= 8'h00;
    end else begin
      rsp_valid_q <= 1'b0;
      if (rb_v) begin
        h0_q <= rb;
        h1_q <= h0_q;
        if (hcnt_q == depth) begin
          rsp_valid_q <= 1'b1;
          rsp_byte_q <= (depth == 2'd2) ? h1_q : h0_q;
        end else begin
          hcnt_q <= 2'(hcnt_q + 2'd1);
        end
      end
    end
  end

  // ****************************
  // completion status
  // ****************************
  always_comb begin
    chk_ok = !mb_q ? (bcc == 8'h00) : (ascii_q ? (sum == 8'h00) : (crc == 16'h0000));
    enough = !mb_q || rcnt_q >= MB_MIN_BYTES;
    if (!chk_ok || !enough) begin
      eval_st = ST_CHECK_ERR;
    end else if (!mb_q || r1_q == func_q) begin
      eval_st = ST_OK;
    end else if (r1_q == (func_q | FC_ERR_FLAG)) begin
      eval_st = ST_SLAVE_ERR;
    end else begin
      eval_st = ST_BAD_REPLY;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      done_q <= 1'b0;
      status_q <= ST_OK;
      req_ready_q <= 1'b1;
    end else begin
      done_q <= 1'b0;
      if (req_take && refuse) begin
        done_q <= 1'b1;
        status_q <= ST_REFUSED;
      end else if (req_take) begin
        req_ready_q <= 1'b0;
      end else if (state_q == S_DRAIN && !tx_valid_q && bcast_q) begin
        done_q <= 1'b1;
        status_q <= ST_BCAST;
        req_ready_q <= 1'b1;
      end else if (state_q == S_WAIT && fin) begin
        done_q <= 1'b1;
        status_q <= eval_st;
        req_ready_q <= 1'b1;
      end else if (state_q == S_WAIT && rpl_exp) begin
        done_q <= 1'b1;
        status_q <= ST_TIMEOUT;
        req_ready_q <= 1'b1;
      end
    end
  end

  assign req_ready = req_ready_q;
  assign pay_ready = pay_ready_q;
  assign tx_valid = tx_valid_q;
  assign tx_char = tx_char_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_byte = rsp_byte_q;
  assign done = done_q;
  assign status = status_q;

  // ****************************
  // checks
  // ****************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_drive_start_byte: assert property (
    adv && state_q == S_BODY && !mb_q && idx_q == 8'h00 |=> tx_char_q == DRV_START)
    else $error("drive telegram did not open with start byte");
  a_word_high_first: assert property (
    adv && state_q == S_BODY && mb_q && !ascii_q && idx_q == MB_WORD_BASE
    |=> tx_char_q == word_q[0][15:8])
    else $error("word not sent high byte first");
  a_word_low_next: assert property (
    adv && state_q == S_BODY && mb_q && !ascii_q && idx_q == 8'(MB_WORD_BASE + 8'h01)
    |=> tx_char_q == word_q[0][7:0])
    else $error("low byte of word not sent second");
  a_drive_bcast_bit: assert property (
    adv && state_q == S_BODY && !mb_q && idx_q == 8'h02 && bcast_q
    |=> tx_char_q[DRV_BCAST_BIT] && tx_char_q[7:6] == 2'b00)
    else $error("drive broadcast address bit missing");
  a_bcast_no_wait: assert property (
    state_q == S_DRAIN && bcast_q && !tx_valid_q
    |=> state_q == S_IDLE && done_q && status_q == ST_BCAST)
    else $error("broadcast did not return straight to idle");
  a_read_bcast_refused: assert property (
    req_take && req_bcast && !req_wr |=> done_q && status_q == ST_REFUSED && state_q == S_IDLE)
    else $error("broadcast read was not refused");
  a_wait_blocks_req: assert property (state_q == S_WAIT |-> !req_ready_q)
    else $error("request accepted during reply delay");
  a_ascii_open: assert property (adv && state_q == S_HDR |=> tx_char_q == ASCII_START)
    else $error("ascii frame not opened by start character");
  a_rtu_gap_quiet: assert property (
    state_q == S_GAP |-> !tx_valid_q throughout (state_q == S_GAP)[*1])
    else $error("character sent during rtu gap");
  a_slave_err_flag: assert property (
    state_q == S_WAIT && fin && chk_ok && enough && mb_q && r1_q == (func_q | FC_ERR_FLAG)
    |=> done_q && status_q == ST_SLAVE_ERR)
    else $error("slave error reply not classified");
  a_timeout_frees: assert property (
    state_q == S_WAIT && rpl_exp && !fin |=> done_q && status_q == ST_TIMEOUT && req_ready_q)
    else $error("reply timeout not reported");

  c_drive_ok: cover property (done_q && status_q == ST_OK && !mb_q);
  c_ascii_ok: cover property (done_q && status_q == ST_OK && mb_q && ascii_q);
  c_rtu_slave_err: cover property (done_q && status_q == ST_SLAVE_ERR && !ascii_q);
  c_timeout: cover property (done_q && status_q == ST_TIMEOUT);
endmodule

// ### testbench/rmf_slave.sv
// behavioural serial slave for the framer line side
module rmf_slave (
  input wire logic sys_clk,
  input wire logic slow,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_char,
  output logic rx_valid,
  output logic [7:0] rx_char
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got [$];
  initial begin
    tx_ready = 1'b1;
    rx_valid = 1'b0;
    rx_char = 8'h00;
  end
  // ****
  // line capture, optionally stalling
  // ****
  always @(posedge sys_clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_char);
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
  // ****
  // reply only when asked, one char every other cycle
  // ****
  task automatic send(input logic [7:0] q[$]);
    foreach (q[i]) begin
      @(posedge sys_clk);
      rx_valid <= 1'b1;
      rx_char <= q[i];
      @(posedge sys_clk);
      rx_valid <= 1'b0;
      rx_char <= ~q[i];
    end
  endtask
endmodule

// ### testbench/testbench.sv
// self-checking bench for the telegram framer
`define CHK(n, e, s) begin compares++; if ((e) !== (s)) begin mismatches++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import rmf_pkg::*;
  logic sys_clk = 0, rst = 1, cfg_valid = 0, cfg_ascii = 0, req_valid = 0, req_drive = 0;
  logic req_write = 0, slow = 0, req_ready, pay_ready, tx_valid, tx_ready, rx_valid;
  logic rsp_valid, done, pvalid = 0;
  logic [7:0] plen = 0, pdata = 8'ha0;
  logic [7:0] req_addr = 0, req_func = 0, tx_char, rx_char, rsp_byte;
  logic [15:0] w [5] = '{default: 16'h0000};
  logic [7:0] rq [$];
  logic [7:0] e [$];
  rmf_status_e status;
  int mismatches = 0, compares = 0, cyc = 0;
  rmf_framer #(.REPLY_CYC(200), .GAP_CYC(20)) rmf_framer_i (.sys_clk(sys_clk), .rst(rst),
    .cfg_valid(cfg_valid), .cfg_ascii(cfg_ascii), .req_valid(req_valid), .req_ready(req_ready),
    .req_drive(req_drive), .req_write(req_write), .req_addr(req_addr), .req_func(req_func),
    .req_w0(w[0]), .req_w1(w[1]), .req_w2(w[2]), .req_w3(w[3]), .req_w4(w[4]),
    .req_pay_len(plen), .pay_valid(pvalid), .pay_ready(pay_ready), .pay_data(pdata),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_char(tx_char), .rx_valid(rx_valid),
    .rx_char(rx_char), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .done(done), .status(status));
  rmf_slave slave_i (.sys_clk(sys_clk), .slow(slow), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_char(tx_char), .rx_valid(rx_valid), .rx_char(rx_char));
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (rsp_valid) rq.push_back(rsp_byte);
    if (pvalid && pay_ready) pdata <= 8'(pdata + 8'h01);
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  // ****
  // shared tasks
  // ****
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic request(input logic d, wr, input logic [7:0] a, f, input logic [15:0] w0, w1);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_drive <= d;
    req_write <= wr;
    req_addr <= a;
    req_func <= f;
    w <= '{w0, w1, 16'h1234, 16'h5678, 16'h9abc};
    @(posedge sys_clk);
    req_valid <= 1'b0;
  endtask
  task automatic finish_req(input rmf_status_e st, input string n);
    for (int i = 0; i < 400 && done !== 1'b1; i++) @(negedge sys_clk);
    `CHK(n, st, status)
  endtask
  task automatic chk_tx(input string n);
    for (int i = 0; i < 400 && slave_i.got.size() < e.size(); i++) @(negedge sys_clk);
    foreach (e[j]) `CHK(n, e[j], slave_i.got[j])
    slave_i.got.delete();
  endtask
  task automatic reply(input logic [7:0] q[$]);
    logic [15:0] c;
    c = crc(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    rq.delete();
    slave_i.send(q);
  endtask
  // ****
  // scenarios
  // ****
  task automatic drv_exp(input logic [7:0] a);
    logic [7:0] b;
    e = '{DRV_START, 8'h0c, a};
    foreach (w[j]) begin
      e.push_back(w[j][15:8]);
      e.push_back(w[j][7:0]);
    end
    b = 8'h00;
    foreach (e[j]) b ^= e[j];
    e.push_back(b);
  endtask
  task automatic drive_bcast();
    request(1'b1, 1'b1, 8'h05, 8'h00, 16'h1111, 16'h2222);
    drv_exp(8'h05);
    chk_tx("drive request");
    rq.delete();
    slave_i.send(e);
    finish_req(ST_OK, "drive reply");
    `CHK("drive reply size", 13, rq.size())
    foreach (rq[j]) `CHK("drive reply", e[j], rq[j])
    request(1'b1, 1'b1, 8'h23, 8'h00, 16'habcd, 16'h0102);
    finish_req(ST_BCAST, "drive bcast");
    drv_exp(8'h23);
    chk_tx("drive frame");
    request(1'b1, 1'b0, 8'h25, 8'h00, 16'h0001, 16'h0002);
    finish_req(ST_REFUSED, "drive read bcast");
    `CHK("refused line", 0, slave_i.got.size())
  endtask
  task automatic rtu_read();
    logic [15:0] c;
    request(1'b0, 1'b0, 8'h11, 8'h03, 16'h0102, 16'h0001);
    e = '{8'h11, 8'h03, 8'h01, 8'h02, 8'h00, 8'h01};
    c = crc(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    chk_tx("rtu request");
    reply('{8'h11, 8'h03, 8'h02, 8'h12, 8'h34});
    finish_req(ST_OK, "rtu ok");
    `CHK("rtu data", 40'h1103021234, {rq[0], rq[1], rq[2], rq[3], rq[4]})
    request(1'b0, 1'b0, 8'h11, 8'h03, 16'h0102, 16'h0001);
    chk_tx("rtu request again");
    reply('{8'h11, 8'h83, 8'h02});
    finish_req(ST_SLAVE_ERR, "rtu slave error");
    request(1'b0, 1'b0, 8'h12, 8'h04, 16'h0000, 16'h0002);
    finish_req(ST_TIMEOUT, "rtu timeout");
    `CHK("tx while waiting", 8, slave_i.got.size())
    slave_i.got.delete();
  endtask
  task automatic rtu_multi();
    logic [15:0] c;
    @(posedge sys_clk);
    plen <= 8'h04;
    pvalid <= 1'b1;
    request(1'b0, 1'b0, 8'h11, 8'h10, 16'h0010, 16'h0002);
    e = '{8'h11, 8'h10, 8'h00, 8'h10, 8'h00, 8'h02, 8'h04, 8'ha0, 8'ha1, 8'ha2, 8'ha3};
    c = crc(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    chk_tx("rtu multi write");
    pvalid <= 1'b0;
    reply('{8'h11, 8'h10, 8'h00, 8'h10, 8'h00, 8'h02});
    finish_req(ST_OK, "rtu multi ok");
  endtask
  task automatic ascii_bcast();
    @(posedge sys_clk);
    cfg_valid <= 1'b1;
    cfg_ascii <= 1'b1;
    slow <= 1'b1;
    @(posedge sys_clk);
    cfg_valid <= 1'b0;
    request(1'b0, 1'b0, MB_BCAST_ADDR, 8'h05, 16'h00ab, 16'h0001);
    finish_req(ST_BCAST, "ascii bcast");
    e = '{8'h3a, 8'h30, 8'h30, 8'h30, 8'h35, 8'h30, 8'h30, 8'h41, 8'h42, 8'h46, 8'h46,
      8'h30, 8'h30, 8'h35, 8'h31, 8'h0d, 8'h0a};
    chk_tx("ascii frame");
    request(1'b0, 1'b0, 8'h07, 8'h01, 16'h0013, 16'h0025);
    e = '{8'h3a, 8'h30, 8'h37, 8'h30, 8'h31, 8'h30, 8'h30, 8'h31, 8'h33, 8'h30, 8'h30,
      8'h32, 8'h35, 8'h43, 8'h30, 8'h0d, 8'h0a};
    chk_tx("ascii bit read");
    rq.delete();
    slave_i.send('{8'h3a, 8'h30, 8'h37, 8'h30, 8'h31, 8'h30, 8'h31, 8'h63, 8'h64, 8'h32,
      8'h41, 8'h0d, 8'h0a});
    finish_req(ST_OK, "ascii reply");
    `CHK("ascii data", 32'h070101cd, {rq[0], rq[1], rq[2], rq[3]})
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    drive_bcast();
    rtu_read();
    rtu_multi();
    ascii_bcast();
    give_verdict();
  end
endmodule
